// ===== common/sysctl_regs.svh
// register offsets, fields, reset values and timing counts for sysctl
`ifndef SYSCTL_REGS_SVH
`define SYSCTL_REGS_SVH
// register byte addresses
`define SYSCTL_CTRL_ADDR   8'h00
`define SYSCTL_INSTR_ADDR  8'h04
`define SYSCTL_PC_ADDR     8'h08
`define SYSCTL_SP_ADDR     8'h0c
`define SYSCTL_ACC_ADDR    8'h10
`define SYSCTL_STATUS_ADDR 8'h14
`define SYSCTL_WAKE_ADDR   8'h18
// control field positions
`define SYSCTL_CTRL_FLAGS_LSB 0
`define SYSCTL_CTRL_ISR_BIT   4
// status field positions
`define SYSCTL_ST_GIE_BIT     0
`define SYSCTL_ST_BUSY_BIT    1
`define SYSCTL_ST_CPUHLT_BIT  2
`define SYSCTL_ST_SYSHLT_BIT  3
`define SYSCTL_ST_RESET_BIT   4
`define SYSCTL_ST_WDCLR_BIT   5
// reset values
`define SYSCTL_PC_RST    11'h000
`define SYSCTL_SP_RST    8'h00
`define SYSCTL_ACC_RST   8'h00
`define SYSCTL_FLAGS_RST 4'h0
// stack step and cycle counts
`define SYSCTL_SP_STEP   8'h02
`define SYSCTL_LONG_T    2'h2
`define SYSCTL_SHORT_T   2'h1
`endif

// ===== common/sysctl_pkg.sv
// types for the system control instruction executor
package sysctl_pkg;
  // opcodes of the system control group
  typedef enum logic [3:0] {
    SYSCTL_OP_NOP, SYSCTL_OP_CALL, SYSCTL_OP_GOTO, SYSCTL_OP_RETI_IMM,
    SYSCTL_OP_RET, SYSCTL_OP_RETI, SYSCTL_OP_PCADD, SYSCTL_OP_ENGINT,
    SYSCTL_OP_DISGINT, SYSCTL_OP_STOPSYS, SYSCTL_OP_STOPEXE,
    SYSCTL_OP_RESET, SYSCTL_OP_WDRESET, SYSCTL_OP_ISR
  } sysctl_op_t;
  // execution sequencer states
  typedef enum logic [1:0] {
    SYSCTL_IDLE, SYSCTL_EXEC, SYSCTL_HALT
  } sysctl_state_t;
endpackage : sysctl_pkg

// ===== rtl/sysctl_exec.sv
// system control instruction executor with a wishbone register port
//
// Implementation choices: register access over Wishbone and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "sysctl_regs.svh"

module sysctl_exec
  import sysctl_pkg::*;
#(
  parameter int PC_W    = 11,
  parameter int STACK_N = 16
) (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        rstn_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // wake-up pin
  input  wire logic        wake_i,
  // system effects
  output logic             gie_o,
  output logic             core_clk_en_o,
  output logic             osc_en_o,
  output logic             chip_reset_o,
  output logic             wdt_clear_o,
  output logic      [3:0]  flags_o
);

  // wishbone request decode
  logic wb_req;
  logic wb_wr;
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr  = wb_req & wb_we_i;

  // wake pin synchroniser
  logic wake_s1_q;
  logic wake_s2_q;
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wake_s1_q <= 1'b0;
      wake_s2_q <= 1'b0;
    end else begin
      wake_s1_q <= wake_i;
      wake_s2_q <= wake_s1_q;
    end
  end

  // architectural state
  logic [PC_W-1:0] pc_q;
  logic [7:0]      sp_q;
  logic [7:0]      acc_q;
  logic [3:0]      flags_q;
  logic            gie_q;
  logic [PC_W-1:0] stack_q [STACK_N];
  logic [PC_W-1:0] target_q;
  sysctl_op_t      op_q;
  sysctl_state_t   state_q;
  logic [1:0]      cyc_q;
  logic            sys_halt_q;
  logic            cpu_halt_q;
  logic            chip_rst_q;
  logic            wd_clr_q;
  logic            core_en_q;
  logic            osc_en_q;

  // instruction issue: a write to the instruction register starts one
  logic            issue;
  sysctl_op_t      issue_op;
  assign issue    = wb_wr && wb_adr_i == `SYSCTL_INSTR_ADDR
                    && state_q == SYSCTL_IDLE && wb_sel_i[0];
  assign issue_op = sysctl_op_t'(wb_dat_i[3:0]);

  // stack index from the pointer (two bytes per slot)
  localparam int IDX_W = $clog2(STACK_N);
  logic [7:0]      sp_dn;
  logic [IDX_W-1:0] push_idx;
  logic [IDX_W-1:0] pop_idx;
  assign sp_dn    = sp_q - `SYSCTL_SP_STEP;
  assign push_idx = sp_q[IDX_W:1];
  assign pop_idx  = sp_dn[IDX_W:1];

  // sequencer: two cycles for flow change except isr, one otherwise, halt waits wake
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_q <= SYSCTL_IDLE;
      cyc_q   <= 2'h0;
      op_q    <= SYSCTL_OP_NOP;
    end else if (chip_rst_q) begin
      // software reset returns the sequencer to idle like a pin reset
      state_q <= SYSCTL_IDLE;
      cyc_q   <= 2'h0;
      op_q    <= SYSCTL_OP_NOP;
    end else begin
      unique case (state_q)
        SYSCTL_IDLE: begin
          if (issue) begin
            op_q    <= issue_op;
            state_q <= SYSCTL_EXEC;
            unique case (issue_op)
              SYSCTL_OP_CALL, SYSCTL_OP_GOTO, SYSCTL_OP_RET,
              SYSCTL_OP_RETI, SYSCTL_OP_RETI_IMM, SYSCTL_OP_PCADD:
                cyc_q <= `SYSCTL_LONG_T;
              default:
                cyc_q <= `SYSCTL_SHORT_T;
            endcase
          end
        end
        SYSCTL_EXEC: begin
          cyc_q <= cyc_q - 2'h1;
          if (cyc_q == 2'h1) begin
            if (op_q == SYSCTL_OP_STOPSYS || op_q == SYSCTL_OP_STOPEXE) begin
              state_q <= SYSCTL_HALT;
            end else begin
              state_q <= SYSCTL_IDLE;
            end
          end
        end
        SYSCTL_HALT: begin
          if (wake_s2_q) begin
            state_q <= SYSCTL_IDLE;
          end
        end
        default: state_q <= SYSCTL_IDLE;
      endcase
    end
  end

  // final cycle of an instruction
  logic done;
  assign done = state_q == SYSCTL_EXEC && cyc_q == 2'h1;

  // program counter and stack pointer
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pc_q <= `SYSCTL_PC_RST;
      sp_q <= `SYSCTL_SP_RST;
    end else if (chip_rst_q) begin
      // software reset restarts the program from the reset vector
      pc_q <= `SYSCTL_PC_RST;
      sp_q <= `SYSCTL_SP_RST;
    end else if (wb_wr && wb_adr_i == `SYSCTL_PC_ADDR
                 && state_q == SYSCTL_IDLE) begin
      pc_q <= wb_dat_i[PC_W-1:0];
    end else if (wb_wr && wb_adr_i == `SYSCTL_SP_ADDR
                 && state_q == SYSCTL_IDLE) begin
      sp_q <= wb_dat_i[7:0];
    end else if (done) begin
      unique case (op_q)
        SYSCTL_OP_CALL, SYSCTL_OP_ISR: begin
          pc_q <= target_q;
          sp_q <= sp_q + `SYSCTL_SP_STEP;
        end
        SYSCTL_OP_GOTO: pc_q <= target_q;
        SYSCTL_OP_RET, SYSCTL_OP_RETI, SYSCTL_OP_RETI_IMM: begin
          sp_q <= sp_dn;
          pc_q <= stack_q[pop_idx];
        end
        SYSCTL_OP_PCADD:
          pc_q <= pc_q + PC_W'(acc_q);
        default: pc_q <= pc_q + PC_W'(1);
      endcase
    end
  end

  // stack memory written on call and isr
  always_ff @(posedge sys_clk_i) begin
    if (done && (op_q == SYSCTL_OP_CALL || op_q == SYSCTL_OP_ISR)) begin
      stack_q[push_idx] <= pc_q + PC_W'(1);
    end
  end

  // jump target latched at issue
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      target_q <= '0;
    end else if (chip_rst_q) begin
      target_q <= '0;
    end else if (issue) begin
      target_q <= wb_dat_i[16 +: PC_W];
    end
  end

  // accumulator: host load or immediate of return-with-immediate
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      acc_q <= `SYSCTL_ACC_RST;
    end else if (chip_rst_q) begin
      acc_q <= `SYSCTL_ACC_RST;
    end else if (issue && issue_op == SYSCTL_OP_RETI_IMM) begin
      acc_q <= wb_dat_i[15:8];
    end else if (wb_wr && wb_adr_i == `SYSCTL_ACC_ADDR
                 && state_q == SYSCTL_IDLE) begin
      acc_q <= wb_dat_i[7:0];
    end
  end

  // alu flags: only the host writes them, of this group only reset clears them
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      flags_q <= `SYSCTL_FLAGS_RST;
    end else if (chip_rst_q) begin
      // the RESET instruction clears them; no other instruction of the group touches them
      flags_q <= `SYSCTL_FLAGS_RST;
    end else if (wb_wr && wb_adr_i == `SYSCTL_CTRL_ADDR) begin
      flags_q <= wb_dat_i[`SYSCTL_CTRL_FLAGS_LSB +: 4];
    end
  end

  // global interrupt enable
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      gie_q <= 1'b0;
    end else if (chip_rst_q) begin
      gie_q <= 1'b0;
    end else if (done) begin
      unique case (op_q)
        SYSCTL_OP_ENGINT:  gie_q <= 1'b1;
        SYSCTL_OP_DISGINT: gie_q <= 1'b0;
        SYSCTL_OP_RETI:    gie_q <= 1'b1;
        SYSCTL_OP_ISR:     gie_q <= 1'b0;
        default:           gie_q <= gie_q;
      endcase
    end
  end

  // halt, reset and watchdog effects
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sys_halt_q <= 1'b0;
      cpu_halt_q <= 1'b0;
      chip_rst_q <= 1'b0;
      wd_clr_q   <= 1'b0;
      core_en_q  <= 1'b1;
      osc_en_q   <= 1'b1;
    end else begin
      chip_rst_q <= done && op_q == SYSCTL_OP_RESET;
      wd_clr_q   <= done && op_q == SYSCTL_OP_WDRESET;
      if (state_q == SYSCTL_HALT && wake_s2_q) begin
        sys_halt_q <= 1'b0;
        cpu_halt_q <= 1'b0;
        core_en_q  <= 1'b1;
        osc_en_q   <= 1'b1;
      end else if (done && op_q == SYSCTL_OP_STOPSYS) begin
        sys_halt_q <= 1'b1;
        core_en_q  <= 1'b0;
        osc_en_q   <= 1'b0;
      end else if (done && op_q == SYSCTL_OP_STOPEXE) begin
        cpu_halt_q <= 1'b1;
        core_en_q  <= 1'b0;
      end
    end
  end

  // outputs straight from flip-flops
  assign gie_o         = gie_q;
  // clock enables have their own flops so no gate sits on the enable path
  assign core_clk_en_o = core_en_q;
  assign osc_en_o      = osc_en_q;
  assign chip_reset_o  = chip_rst_q;
  assign wdt_clear_o   = wd_clr_q;
  assign flags_o       = flags_q;

  // wishbone read data and single-cycle ack
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= 32'h0;
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          `SYSCTL_CTRL_ADDR:  wb_dat_o <= {28'h0, flags_q};
          `SYSCTL_INSTR_ADDR: wb_dat_o <= {28'h0, op_q};
          `SYSCTL_PC_ADDR:    wb_dat_o <= 32'(pc_q);
          `SYSCTL_SP_ADDR:    wb_dat_o <= {24'h0, sp_q};
          `SYSCTL_ACC_ADDR:   wb_dat_o <= {24'h0, acc_q};
          `SYSCTL_STATUS_ADDR:
            wb_dat_o <= {26'h0, wd_clr_q, chip_rst_q, sys_halt_q,
                         cpu_halt_q, state_q != SYSCTL_IDLE, gie_q};
          default:            wb_dat_o <= 32'h0;
        endcase
      end
    end
  end

endmodule : sysctl_exec
`default_nettype wire

// ===== testbench/sysctl_exec_props.sv
// assertion checker watching the system control executor ports
`timescale 1ns/10ps
`default_nettype none
module sysctl_exec_props (
  // clock, reset and bus
  input wire logic       sys_clk_i,
  input wire logic       rstn_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic       wb_ack_o,
  // system effects
  input wire logic       gie_o,
  input wire logic       core_clk_en_o,
  input wire logic       osc_en_o,
  input wire logic       chip_reset_o,
  input wire logic       wdt_clear_o,
  input wire logic [3:0] flags_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  logic [2:0] age_q;
  logic       wr_q;
  wire logic  take_w = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i;
  // age of the last instruction write, and a flag write marker
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      age_q <= 3'h7;
      wr_q  <= 1'b0;
    end else begin
      wr_q <= take_w && wb_adr_i == 8'h00;
      if (take_w && wb_adr_i == 8'h04) age_q <= 3'h0;
      else if (age_q != 3'h7) age_q <= age_q + 3'h1;
    end
  end
  sequence taken_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence pulse_s; wb_ack_o ##1 !wb_ack_o; endsequence
  ack_once_a: assert property (taken_s |=> pulse_s)
    else $error("ack not a single pulse after request");
  osc_core_a: assert property (!osc_en_o |-> !core_clk_en_o)
    else $error("core clock runs with oscillators off");
  gie_cause_a: assert property ($changed(gie_o) |-> age_q < 3'h6)
    else $error("global enable moved without instruction");
  wdc_cause_a: assert property ($rose(wdt_clear_o) |-> age_q < 3'h6)
    else $error("watchdog clear without instruction");
  rst_cause_a: assert property ($rose(chip_reset_o) |-> age_q < 3'h6)
    else $error("chip reset without instruction");
  wdc_pulse_a: assert property (wdt_clear_o |=> !wdt_clear_o)
    else $error("watchdog clear longer than one cycle");
  rst_pulse_a: assert property (chip_reset_o |=> !chip_reset_o)
    else $error("chip reset longer than one cycle");
  halt_cause_a: assert property ($fell(core_clk_en_o) |-> age_q < 3'h6)
    else $error("core clock stopped without instruction");
  flags_hold_a: assert property ($changed(flags_o) |-> wr_q || $past(wr_q) || $past(chip_reset_o))
    else $error("flags changed without a flag write");
endmodule : sysctl_exec_props
`default_nettype wire

// ===== testbench/sysctl_exec_tb.sv
// self-checking bench for the system control executor
`timescale 1ns/10ps
`default_nettype none
module sysctl_exec_tb
  import sysctl_pkg::*;
;
  logic        sys_clk = 1'b0;
  logic        rstn = 1'b0;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we = 1'b0;
  logic        wake = 1'b0;
  logic [3:0]  sel = 4'hf;
  logic [7:0]  adr = 8'h00;
  logic [31:0] dat = 32'h0;
  logic [31:0] rdat;
  logic        ack, gie, core_en, osc_en, crst, wclr;
  logic [3:0]  flags;
  int          fail_count = 0;
  int          n_checks = 0;
  int          n_wclr = 0;
  int          n_crst = 0;
  // 25 MHz clock
  always #20 sys_clk = ~sys_clk;
  // count single-cycle effect pulses
  always @(posedge sys_clk) begin
    n_wclr <= n_wclr + int'(wclr === 1'b1);
    n_crst <= n_crst + int'(crst === 1'b1);
  end
  sysctl_exec u_sysctl_exec (
    .sys_clk_i(sys_clk), .rstn_i(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .wake_i(wake), .gie_o(gie),
    .core_clk_en_o(core_en), .osc_en_o(osc_en), .chip_reset_o(crst),
    .wdt_clear_o(wclr), .flags_o(flags)
  );
  task automatic give_verdict();
    if (fail_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // a used-up wait ends the run
  task automatic bound(input logic hit);
    if (hit) begin
      fail_count++;
      give_verdict();
    end
  endtask : bound
  // one classic cycle, read data taken at the ack edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    bound(n >= 40);
    @(posedge sys_clk);
  endtask : wb
  task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk(nm, r, e);
  endtask : rd
  // issue one instruction, then poll busy unless it halts
  task automatic ex(input sysctl_op_t op, input logic [10:0] t,
                    input logic [7:0] i);
    logic [31:0] r;
    int n;
    n = 0;
    wb(1'b1, 8'h04, {5'h0, t, i, 4'h0, op}, r);
    if (op inside {SYSCTL_OP_STOPSYS, SYSCTL_OP_STOPEXE}) begin
      repeat (3) @(posedge sys_clk);
    end else begin
      do begin
        wb(1'b0, 8'h14, 32'h0, r);
        n++;
      end while (r[1] !== 1'b0 && n < 20);
    end
    bound(n >= 20);
  endtask : ex
  task automatic t_flow();
    logic [31:0] r;
    wb(1'b1, 8'h00, 32'ha, r);
    ex(SYSCTL_OP_GOTO, 11'h123, 8'h00);
    rd("pc goto", 8'h08, 32'h123);
    ex(SYSCTL_OP_CALL, 11'h400, 8'h00);
    ex(SYSCTL_OP_CALL, 11'h7ff, 8'h00);
    rd("pc call", 8'h08, 32'h7ff);
    rd("sp call", 8'h0c, 32'h4);
    ex(SYSCTL_OP_RET, 11'h0, 8'h00);
    rd("pc ret", 8'h08, 32'h401);
    rd("sp ret", 8'h0c, 32'h2);
    ex(SYSCTL_OP_RETI_IMM, 11'h0, 8'h55);
    rd("acc imm", 8'h10, 32'h55);
    rd("pc imm", 8'h08, 32'h124);
    ex(SYSCTL_OP_PCADD, 11'h0, 8'h00);
    rd("pc add", 8'h08, 32'h179);
    ex(SYSCTL_OP_NOP, 11'h0, 8'h00);
    chk("flags", {28'h0, flags}, 32'ha);
  endtask : t_flow
  task automatic t_gie();
    ex(SYSCTL_OP_ENGINT, 11'h0, 8'h00);
    chk("gie on", {31'h0, gie}, 32'h1);
    ex(SYSCTL_OP_ISR, 11'h300, 8'h00);
    chk("gie isr", {31'h0, gie}, 32'h0);
    ex(SYSCTL_OP_RETI, 11'h0, 8'h00);
    chk("gie reti", {31'h0, gie}, 32'h1);
    rd("sp reti", 8'h0c, 32'h0);
    ex(SYSCTL_OP_DISGINT, 11'h0, 8'h00);
    chk("gie off", {31'h0, gie}, 32'h0);
  endtask : t_gie
  // raise wake until the core clock returns
  task automatic wake_up();
    int n;
    n = 0;
    wake <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
    end while (core_en !== 1'b1 && n < 20);
    wake <= 1'b0;
    bound(n >= 20);
    repeat (2) @(posedge sys_clk);
  endtask : wake_up
  task automatic t_halt();
    ex(SYSCTL_OP_GOTO, 11'h050, 8'h00);
    ex(SYSCTL_OP_STOPEXE, 11'h0, 8'h00);
    chk("core exe", {31'h0, core_en}, 32'h0);
    chk("osc exe", {31'h0, osc_en}, 32'h1);
    wake_up();
    rd("pc wake", 8'h08, 32'h051);
    ex(SYSCTL_OP_STOPSYS, 11'h0, 8'h00);
    chk("core sys", {31'h0, core_en}, 32'h0);
    chk("osc sys", {31'h0, osc_en}, 32'h0);
    wake_up();
    rd("pc wake2", 8'h08, 32'h052);
  endtask : t_halt
  task automatic t_pulse();
    int w, c;
    w = n_wclr;
    c = n_crst;
    ex(SYSCTL_OP_WDRESET, 11'h0, 8'h00);
    chk("wdt clear", n_wclr - w, 32'h1);
    chk("no reset", n_crst - c, 32'h0);
    ex(SYSCTL_OP_RESET, 11'h0, 8'h00);
    chk("chip reset", n_crst - c, 32'h1);
    rd("pc reset", 8'h08, 32'h0);
    chk("flags reset", {28'h0, flags}, 32'h0);
  endtask : t_pulse
  initial begin
    repeat (20) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    t_flow();
    t_gie();
    t_halt();
    t_pulse();
    give_verdict();
  end
endmodule : sysctl_exec_tb
bind sysctl_exec sysctl_exec_props u_sysctl_exec_props (
  .sys_clk_i, .rstn_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_ack_o,
  .gie_o, .core_clk_en_o, .osc_en_o, .chip_reset_o, .wdt_clear_o, .flags_o
);
`default_nettype wire
